// ==== bviu_pkg.sv ====
// Package: constants and carrier types for the board vectored interrupt unit
`default_nettype none
package bviu_pkg;
  localparam int          NUM_LEVELS     = 8;
  localparam int          NUM_SOURCES    = 18;
  localparam int          SEL_W          = 5;
  localparam logic [19:0] NMI_VECTOR     = 20'h00008;
  localparam logic [7:0]  MASK_RST       = 8'hff;
  localparam logic [4:0]  VEC_BASE_RST   = 5'h08;
  localparam logic [2:0]  LOWEST_RST     = 3'h7;
  localparam int          VEC_SPACING    = 4;
  localparam int          TABLE_BYTES    = 32;
  localparam int          VEC_REGION     = 1024;
  localparam int          TOTAL_LEVELS   = 65;
  // Request source indices on the jumper field
  localparam logic [4:0]  SRC_PAR_IBF    = 5'h00;
  localparam logic [4:0]  SRC_PAR_OBE    = 5'h01;
  localparam logic [4:0]  SRC_SER_RXRDY  = 5'h02;
  localparam logic [4:0]  SRC_SER_TXE    = 5'h03;
  localparam logic [4:0]  SRC_TMR0       = 5'h04;
  localparam logic [4:0]  SRC_TMR1       = 5'h05;
  localparam logic [4:0]  SRC_EXT_LINE   = 5'h06;
  localparam logic [4:0]  SRC_BUS_BASE   = 5'h07;
  localparam logic [4:0]  SRC_BUS_TMO    = 5'h0f;
  localparam logic [4:0]  SRC_COPRO_ERR  = 5'h10;
  localparam logic [4:0]  SRC_COPRO_EXC  = 5'h11;

  typedef enum logic [1:0] {
    MODE_NESTED,
    MODE_ROTATE,
    MODE_SPECIFIC,
    MODE_POLLED
  } prio_mode_e;

  typedef struct packed {
    prio_mode_e mode;
    logic [2:0] lowest;
    logic [7:0] mask;
    logic [7:0] edge_trig;
    logic [4:0] vec_base;
  } ctrl_cfg_s;

  typedef struct packed {
    logic       par_ibf;
    logic       par_obe;
    logic       ser_rxrdy;
    logic       ser_txe;
    logic       tmr0;
    logic       tmr1;
    logic       ext_line;
    logic [7:0] bus_req;
    logic       bus_timeout;
    logic       copro_err;
    logic       copro_exc;
  } req_src_s;
endpackage
`default_nettype wire

// ==== board_vectored_interrupt_unit.sv ====
// Board vectored interrupt unit: non-maskable level plus eight-level priority vector controller
`default_nettype none

module board_vectored_interrupt_unit
  import bviu_pkg::*;
#(
  parameter int LEVELS = NUM_LEVELS
) (
  input  wire logic                           sys_clk,
  input  wire logic                           nrst,
  input  wire req_src_s                       src_pins,
  input  wire logic [LEVELS-1:0][SEL_W-1:0]   level_sel,
  input  wire logic                           power_fail_req,
  input  wire logic                           mains_low_warning,
  input  wire ctrl_cfg_s                      cfg,
  input  wire logic                           inta,
  input  wire logic                           eoi,
  input  wire logic                           poll_rd,
  output logic                                nmi,
  output logic                                intr,
  output logic [7:0]                          vector_id,
  output logic                                vector_valid,
  output logic [7:0]                          poll_status,
  output logic [7:0]                          in_service,
  output logic [7:0]                          pending,
  output logic [7:0]                          mask_readback
);

  logic [NUM_SOURCES-1:0] src_flat;
  logic [NUM_SOURCES-1:0] src_m_q;
  logic [NUM_SOURCES-1:0] src_s_q;
  logic [1:0]             pf_m_q;
  logic [1:0]             pf_s_q;
  logic [LEVELS-1:0]      line_lvl;
  logic [LEVELS-1:0]      line_prev_q;
  logic [LEVELS-1:0]      irr_q;
  logic [LEVELS-1:0]      isr_q;
  logic [2:0]             rot_low_q;
  logic [2:0]             low_eff;
  logic                   req_found;
  logic [2:0]             req_idx;
  logic                   isr_found;
  logic [2:0]             isr_idx;
  logic                   fire;

  // Bus timeout at 0x0f, coprocessor at 0x10/0x11
  assign src_flat = {src_pins.copro_exc, src_pins.copro_err, src_pins.bus_timeout,
                     src_pins.bus_req,
                     src_pins.ext_line, src_pins.tmr1, src_pins.tmr0,
                     src_pins.ser_txe, src_pins.ser_rxrdy,
                     src_pins.par_obe, src_pins.par_ibf};

  // All pins are asynchronous to sys_clk
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      src_m_q <= '0;
      src_s_q <= '0;
    end else begin
      src_m_q <= src_flat;
      src_s_q <= src_m_q;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pf_m_q <= '0;
      pf_s_q <= '0;
    end else begin
      pf_m_q <= {mains_low_warning, power_fail_req};
      pf_s_q <= pf_m_q;
    end
  end

  // Non-maskable path: no mask or mode setting reaches it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      nmi <= 1'b0;
    end else begin
      nmi <= pf_s_q[0] & pf_s_q[1];
    end
  end

  // Jumper routing: each controller line picks one of the sources
  genvar g;
  generate
    for (g = 0; g < LEVELS; g++) begin : g_route
      assign line_lvl[g] = (level_sel[g] < SEL_W'(NUM_SOURCES)) ? src_s_q[level_sel[g]] : 1'b0;
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      line_prev_q <= '0;
    end else begin
      line_prev_q <= line_lvl;
    end
  end

  // Request latch; a new edge in the acknowledge cycle survives the clear
  generate
    for (g = 0; g < LEVELS; g++) begin : g_irr
      logic set_req;
      assign set_req = cfg.edge_trig[g] ? (line_lvl[g] & ~line_prev_q[g]) : line_lvl[g];
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          irr_q[g] <= 1'b0;
        end else if (set_req) begin
          irr_q[g] <= 1'b1;
        end else if (!cfg.edge_trig[g] && !line_lvl[g]) begin
          irr_q[g] <= 1'b0;
        end else if (((inta && vector_valid == 1'b0 && intr) || (poll_rd && req_found))
                     && req_idx == 3'(g)) begin
          irr_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Lowest-priority line per mode, read live so changes apply at once
  always_comb begin
    unique case (cfg.mode)
      MODE_ROTATE:   low_eff = rot_low_q;
      MODE_SPECIFIC: low_eff = cfg.lowest;
      MODE_NESTED:   low_eff = LOWEST_RST;
      MODE_POLLED:   low_eff = LOWEST_RST;
    endcase
  end

  // Scan down to the line after the lowest; last hit is highest priority
  always_comb begin
    logic [2:0] k;
    logic [7:0] req_m;
    req_found = 1'b0;
    req_idx   = 3'h0;
    isr_found = 1'b0;
    isr_idx   = 3'h0;
    k         = 3'h0;
    req_m     = irr_q & ~cfg.mask;
    for (int i = 7; i >= 0; i--) begin
      k = low_eff + 3'(i) + 3'h1;
      if (req_m[k]) begin
        req_found = 1'b1;
        req_idx   = k;
      end
      if (isr_q[k]) begin
        isr_found = 1'b1;
        isr_idx   = k;
      end
    end
  end

  // Lower rank means nearer to low_eff+1, the highest-priority position
  always_comb begin
    logic [2:0] rank_req;
    logic [2:0] rank_isr;
    rank_req = req_idx - low_eff - 3'h1;
    rank_isr = isr_idx - low_eff - 3'h1;
    fire = req_found && (!isr_found || rank_req < rank_isr) && cfg.mode != MODE_POLLED;
  end

  // Request stays raised until acknowledged
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      intr <= 1'b0;
    end else if (inta && intr) begin
      intr <= 1'b0;
    end else if (!intr) begin
      intr <= fire;
    end
  end

  // Identifier = aligned base (in 8-entry blocks) plus level; base kept under 1K / 4
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      vector_id    <= 8'h00;
      vector_valid <= 1'b0;
    end else begin
      vector_valid <= inta && intr;
      if (inta && intr) begin
        vector_id <= {cfg.vec_base, req_idx};
      end
    end
  end

  // In-service marking and release; rotating mode moves the lowest level
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      isr_q     <= '0;
      rot_low_q <= LOWEST_RST;
    end else begin
      if (eoi && isr_found) begin
        isr_q[isr_idx] <= 1'b0;
        if (cfg.mode == MODE_ROTATE) begin
          rot_low_q <= isr_idx;
        end
      end
      // A request that vanished before the acknowledge marks nothing in service
      if (inta && intr && req_found) begin
        isr_q[req_idx] <= 1'b1;
      end
    end
  end

  // Polled word: bit7 = request present, low bits = encoded level
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      poll_status <= 8'h00;
    end else begin
      poll_status <= {req_found, 4'h0, req_idx};
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      in_service    <= 8'h00;
      pending       <= 8'h00;
      mask_readback <= MASK_RST;
    end else begin
      in_service    <= isr_q;
      pending       <= irr_q;
      mask_readback <= cfg.mask;
    end
  end

endmodule
`default_nettype wire

// ==== bviu_monitor.sv ====
// Port checker for the vectored interrupt unit
`default_nettype none
module bviu_monitor
  import bviu_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire ctrl_cfg_s  cfg,
  input wire logic       inta,
  input wire logic       power_fail_req,
  input wire logic       mains_low_warning,
  input wire logic       nmi,
  input wire logic       intr,
  input wire logic [7:0] vector_id,
  input wire logic       vector_valid,
  input wire logic [7:0] pending,
  input wire logic [7:0] mask_readback
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_ack; intr && inta; endsequence
  sequence s_vec; ##1 vector_valid ##1 !vector_valid; endsequence
  property p_nmi; $past(nrst, 3) |-> nmi == $past(power_fail_req && mains_low_warning, 3); endproperty
  a_nmi: assert property (p_nmi) else $error("nmi lag wrong");
  property p_ack; s_ack |-> s_vec; endproperty
  a_ack: assert property (p_ack) else $error("no vector pulse");
  property p_drop; s_ack |=> !intr; endproperty
  a_drop: assert property (p_drop) else $error("intr kept");
  property p_hold; intr && !inta |=> intr; endproperty
  a_hold: assert property (p_hold) else $error("intr lost");
  property p_base; vector_valid |-> vector_id[7:3] == cfg.vec_base; endproperty
  a_base: assert property (p_base) else $error("bad vector base");
  property p_poll; $rose(intr) |-> $past(cfg.mode) != MODE_POLLED; endproperty
  a_poll: assert property (p_poll) else $error("intr in polled");
  property p_pend; $rose(intr) |-> pending != 8'h00; endproperty
  a_pend: assert property (p_pend) else $error("intr no request");
  property p_mask; $past(nrst) |-> mask_readback == $past(cfg.mask); endproperty
  a_mask: assert property (p_mask) else $error("mask readback");
endmodule
bind board_vectored_interrupt_unit bviu_monitor i_bviu_monitor (.sys_clk(sys_clk), .nrst(nrst), .cfg(cfg), .inta(inta),
  .power_fail_req(power_fail_req), .mains_low_warning(mains_low_warning), .nmi(nmi), .intr(intr),
  .vector_id(vector_id), .vector_valid(vector_valid), .pending(pending), .mask_readback(mask_readback));
`default_nettype wire

// ==== bviu_cpu_model.sv ====
// Processor model: acknowledges, fetches the identifier, ends service
`default_nettype none
module bviu_cpu_model
  import bviu_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       nmi,
  input  wire logic       intr,
  input  wire logic       vector_valid,
  input  wire logic [7:0] vector_id,
  input  wire logic [3:0] delay,
  output logic            inta,
  output logic            eoi,
  output logic [9:0]      vec_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  logic [2:0] done_q;
  logic       nmi_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wait_q <= 4'h0;
      inta <= 1'b0;
    end else begin
      // Held until intr is seen low, so the request never vanishes early
      wait_q <= intr ? wait_q + 4'(wait_q != 4'hf) : 4'h0;
      inta <= intr && (wait_q >= delay);
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      done_q <= 3'h0;
      eoi <= 1'b0;
      nmi_q <= 1'b0;
      vec_addr <= 10'h000;
    end else begin
      done_q <= {done_q[1:0], vector_valid};
      eoi <= done_q[2];
      nmi_q <= nmi;
      if (nmi && !nmi_q) begin
        vec_addr <= NMI_VECTOR[9:0];
      end else if (vector_valid) begin
        vec_addr <= {vector_id, 2'b00};
      end
    end
  end
endmodule
`default_nettype wire

// ==== board_vectored_interrupt_unit_tb_top.sv ====
// Testbench for the board vectored interrupt unit
`default_nettype none
module board_vectored_interrupt_unit_tb_top
  import bviu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic            sys_clk, nrst, pfr, mlw, poll_rd, inta, eoi, nmi, intr, vector_valid;
  req_src_s        src_pins;
  logic [7:0][4:0] level_sel;
  ctrl_cfg_s       cfg;
  logic [7:0]      vector_id, poll_status, in_service, pending, mask_readback, lfsr;
  logic [9:0]      vec_addr;
  logic [3:0]      delay;
  logic [2:0]      got[$];
  int              num_errors, samples_checked;
  board_vectored_interrupt_unit i_board_vectored_interrupt_unit (.sys_clk(sys_clk), .nrst(nrst), .src_pins(src_pins),
    .level_sel(level_sel), .power_fail_req(pfr), .mains_low_warning(mlw), .cfg(cfg), .inta(inta), .eoi(eoi),
    .poll_rd(poll_rd), .nmi(nmi), .intr(intr), .vector_id(vector_id), .vector_valid(vector_valid),
    .poll_status(poll_status), .in_service(in_service), .pending(pending), .mask_readback(mask_readback));
  bviu_cpu_model i_bviu_cpu_model (.sys_clk(sys_clk), .nrst(nrst), .nmi(nmi), .intr(intr), .vector_valid(vector_valid),
    .vector_id(vector_id), .delay(delay), .inta(inta), .eoi(eoi), .vec_addr(vec_addr));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) if (vector_valid === 1'b1) got.push_back(vector_id[2:0]);
  function automatic logic [7:0] step(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Struct bit of a source: scalars run downward from bit 17, the bus byte keeps its own order
  function automatic int pin_of(input int s);
    return (s >= int'(SRC_BUS_BASE) && s < int'(SRC_BUS_BASE) + 8) ? s - 4 : 17 - s;
  endfunction
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Grant order is walked from the top-ranked line; masked lines are drained after
  task automatic run(input prio_mode_e m, input logic [2:0] start, input logic [7:0] lines, input logic [7:0] msk);
    logic [2:0] l;
    logic [2:0] last;
    int n;
    @(negedge sys_clk);
    cfg.mode = m;
    cfg.lowest = start - 3'h1;
    cfg.mask = msk;
    got.delete();
    for (int i = 0; i < 8; i++) if (lines[i]) src_pins[pin_of(int'(level_sel[i]))] = 1'b1;
    repeat (3) @(negedge sys_clk);
    src_pins = '0;
    n = $countones(lines & ~msk);
    for (int t = 0; t < 500 && got.size() < n; t++) @(negedge sys_clk);
    repeat (20) @(negedge sys_clk);
    check(10'(got.size()), 10'(n));
    for (int k = 0; k < 8; k++) begin
      l = start + 3'(k);
      if (lines[l] && !msk[l] && got.size() > 0) begin
        check(got.pop_front(), l);
        last = l;
      end
    end
    if (n > 0) check(vec_addr, {cfg.vec_base, last, 2'b00});
    cfg.mask = 8'h00;
    if (msk != 8'h00) repeat (200) @(negedge sys_clk);
    $display("run mode %0d lines %h done", m, lines);
  endtask
  initial begin
    #400us;
    num_errors++;
    give_verdict();
  end
  initial begin
    nrst = 1'b0;
    {pfr, mlw, poll_rd} = 3'b000;
    src_pins = '0;
    for (int i = 0; i < 8; i++) level_sel[i] = 5'(i);
    cfg = '{MODE_NESTED, 3'h7, 8'h00, 8'hff, 5'h08};
    delay = 4'h0;
    lfsr = 8'h4e;
    repeat (12) @(negedge sys_clk);
    check(mask_readback, MASK_RST);
    nrst = 1'b1;
    cfg.vec_base = {1'b1, lfsr[3:0]};
    for (int s = 0; s < 18; s++) begin
      level_sel[s % 8] = 5'(s);
      run(MODE_NESTED, 3'h0, 8'(1 << (s % 8)), 8'h00);
      level_sel[s % 8] = 5'(s % 8);
    end
    run(MODE_NESTED, 3'h0, 8'h24, 8'h00);
    run(MODE_NESTED, 3'h0, 8'h24, 8'h04);
    run(MODE_ROTATE, 3'h1, 8'h01, 8'h00);
    run(MODE_ROTATE, 3'h1, 8'h03, 8'h00);
    run(MODE_SPECIFIC, 3'h4, 8'h24, 8'h00);
    for (int r = 0; r < 8; r++) begin
      lfsr = step(lfsr);
      delay = lfsr[3:0];
      run(MODE_NESTED, 3'h0, lfsr, step(lfsr) & 8'h0f);
    end
    cfg.mode = MODE_POLLED;
    src_pins[11] = 1'b1;
    repeat (8) @(negedge sys_clk);
    check(intr, 1'b0);
    check(poll_status, 8'h86);
    poll_rd = 1'b1;
    @(negedge sys_clk);
    {poll_rd, src_pins} = '0;
    repeat (4) @(negedge sys_clk);
    check(pending, 8'h00);
    cfg.edge_trig = 8'hbf;
    src_pins[pin_of(int'(SRC_EXT_LINE))] = 1'b1;
    repeat (8) @(negedge sys_clk);
    check(pending[6], 1'b1);
    src_pins = '0;
    repeat (6) @(negedge sys_clk);
    check(pending, 8'h00);
    check(in_service, 8'h00);
    cfg.mask = 8'hff;
    pfr = 1'b1;
    repeat (5) @(negedge sys_clk);
    check(nmi, 1'b0);
    mlw = 1'b1;
    repeat (5) @(negedge sys_clk);
    check(nmi, 1'b1);
    check(vec_addr, 10'(NMI_VECTOR));
    $display("polled and nmi done");
    give_verdict();
  end
endmodule
`default_nettype wire
